// ==== common/coau_pkg.sv ====
// shared types and constants for the operand addressing unit
package coau_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 16;
   localparam int BIT_SPACE = 256;
   localparam int BIT_RAM_COUNT = 128;
   localparam logic [7:0] BIT_RAM_BASE = 8'h20;
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [7:0] DIRECT_MAX = 8'hFF;
   localparam logic [1:0] MULTI_CYCLES = 2'h2;

   // operand addressing modes
   typedef enum logic [2:0] {
      COAU_DIRECT,
      COAU_INDIRECT8,
      COAU_INDIRECT16,
      COAU_REGISTER,
      COAU_REGSPEC,
      COAU_IMMEDIATE,
      COAU_INDEXED,
      COAU_BIT
   } coau_mode_t;

   // instruction classes
   typedef enum logic [2:0] {
      COAU_ARITH,
      COAU_LOGIC,
      COAU_XFER,
      COAU_BOOL,
      COAU_BRANCH
   } coau_class_t;

   // target spaces
   typedef enum logic [2:0] {
      COAU_SP_NONE,
      COAU_SP_IRAM,
      COAU_SP_SFR,
      COAU_SP_XDATA,
      COAU_SP_CODE,
      COAU_SP_VALUE
   } coau_space_t;

   // decode request from the instruction stream
   typedef struct packed {
      coau_mode_t mode;
      coau_class_t iclass;
      logic [2:0] regNum;
      logic ptrSel;
      logic [7:0] field;
      logic [1:0] bank;
      logic twoCycle;
   } coau_req_t;

   // resolved operand
   typedef struct packed {
      coau_space_t space;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] value;
      logic [2:0] bitPos;
      logic isBit;
      coau_class_t iclass;
   } coau_opnd_t;
endpackage

// ==== logic/coau_operand_unit.sv ====
// operand address generation and decode
`timescale 1ns/1ps
// Notes on behaviour
// - direct mode takes an 8-bit address; reaches internal RAM or special registers only
// - 8-bit indirect reads address from general_reg_zero or general_reg_one
// - 16-bit indirect uses data_pointer as the full address
// - register mode picks one of eight registers in current bank
// - register-specific instructions use a fixed register, accumulator, no field decode
// - immediate mode passes the single 8-bit instruction field byte as the value
// - indexed mode reads program memory at data_pointer plus accumulator
// - bit mode selects one bit of a 256-location bit space
// - five instruction classes are accepted
// - instructions finish in one or two cycles
// - low 128 bit addresses map to RAM, rest to special register bits
module coau_operand_unit
   import coau_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic reqValid,
   input wire coau_req_t req,
   input wire logic [DATA_W-1:0] accumulator,
   input wire logic [ADDR_W-1:0] data_pointer,
   input wire logic [DATA_W-1:0] regRdData,
   output logic [7:0] regRdAddr,
   output logic reqReady,
   output logic opndValid,
   output coau_opnd_t opnd,
   output logic illegal
);
   typedef enum logic [1:0] {COAU_IDLE, COAU_HOLD} coau_state_t;

   coau_state_t state;
   coau_state_t next_state;
   coau_req_t held;
   coau_req_t next_held;
   coau_opnd_t next_opnd;
   logic next_opndValid;
   logic next_illegal;

   // general register address in a bank: bank*8 + number
   function automatic logic [7:0] bankReg(input logic [1:0] bank, input logic [2:0] num);
      return {3'h0, bank, num};
   endfunction

   // bit address to byte address; bit position is the low three bits, taken outside
   function automatic logic [7:0] bitByte(input logic [7:0] bitAddr);
      logic [7:0] res;
      res = 8'h00;
      if (bitAddr < 8'(BIT_RAM_COUNT)) begin
         res = BIT_RAM_BASE + {3'h0, bitAddr[6:3]};
      end else begin
         res = {bitAddr[7:3], 3'h0};
      end
      return res;
   endfunction

   // register file read address drives pointer and register modes
   always_comb begin
      case (req.mode)
         COAU_INDIRECT8: regRdAddr = bankReg(req.bank, {2'h0, req.ptrSel});
         COAU_REGISTER: regRdAddr = bankReg(req.bank, req.regNum);
         default: regRdAddr = 8'h00;
      endcase
   end

   // two-cycle instructions stall the stream for one extra cycle
   assign reqReady = (state == COAU_IDLE);

   // decode next operand
   always_comb begin
      next_state = state;
      next_held = held;
      next_opnd = opnd;
      next_opndValid = 1'b0;
      next_illegal = 1'b0;
      if (state == COAU_HOLD) begin
         next_state = COAU_IDLE;
      end else if (reqValid) begin
         next_opndValid = 1'b1;
         next_held = req;
         next_opnd = '0;
         next_opnd.iclass = req.iclass;
         if (req.iclass > COAU_BRANCH) begin
            next_illegal = 1'b1;
            next_opndValid = 1'b0;
         end
         case (req.mode)
            COAU_DIRECT: begin
               next_opnd.addr = {8'h00, req.field};
               next_opnd.space = (req.field < SFR_BASE) ? COAU_SP_IRAM : COAU_SP_SFR;
            end
            COAU_INDIRECT8: begin
               next_opnd.addr = {8'h00, regRdData};
               next_opnd.space = COAU_SP_IRAM;
            end
            COAU_INDIRECT16: begin
               next_opnd.addr = data_pointer;
               next_opnd.space = COAU_SP_XDATA;
            end
            COAU_REGISTER: begin
               next_opnd.addr = {8'h00, bankReg(req.bank, req.regNum)};
               next_opnd.value = regRdData;
               next_opnd.space = COAU_SP_IRAM;
            end
            COAU_REGSPEC: begin
               next_opnd.value = accumulator;
               next_opnd.space = COAU_SP_VALUE;
            end
            COAU_IMMEDIATE: begin
               next_opnd.value = req.field;
               next_opnd.space = COAU_SP_VALUE;
            end
            COAU_INDEXED: begin
               next_opnd.addr = ADDR_W'(data_pointer + {8'h00, accumulator});
               next_opnd.space = COAU_SP_CODE;
            end
            COAU_BIT: begin
               next_opnd.isBit = 1'b1;
               next_opnd.bitPos = req.field[2:0];
               next_opnd.addr = {8'h00, bitByte(req.field)};
               next_opnd.space = (req.field < 8'(BIT_RAM_COUNT)) ? COAU_SP_IRAM : COAU_SP_SFR;
            end
            default: begin
               next_illegal = 1'b1;
               next_opndValid = 1'b0;
            end
         endcase
         if (req.twoCycle && next_opndValid) begin
            next_state = COAU_HOLD;
         end
      end
   end

   // state and output registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= COAU_IDLE;
         held <= '0;
         opnd <= '0;
         opndValid <= 1'b0;
         illegal <= 1'b0;
      end else begin
         state <= next_state;
         held <= next_held;
         opnd <= next_opnd;
         opndValid <= next_opndValid;
         illegal <= next_illegal;
      end
   end

   property p_direct;
      @(posedge ref_clk) disable iff (!nrst)
      (reqReady && reqValid && req.mode == COAU_DIRECT) |=>
         (opnd.addr[15:8] == 8'h00) && (opnd.space inside {COAU_SP_IRAM, COAU_SP_SFR});
   endproperty
   a_direct: assert property (p_direct) else $error("direct operand out of space");

   property p_ind8;
      @(posedge ref_clk) disable iff (!nrst)
      (reqReady && reqValid && req.mode == COAU_INDIRECT8) |=>
         opnd.addr == {8'h00, $past(regRdData)} && $past(regRdAddr) == {3'h0, $past(req.bank), 2'h0, $past(req.ptrSel)};
   endproperty
   a_ind8: assert property (p_ind8) else $error("indirect pointer wrong");

   property p_ind16;
      @(posedge ref_clk) disable iff (!nrst)
      (reqReady && reqValid && req.mode == COAU_INDIRECT16) |=> opnd.addr == $past(data_pointer);
   endproperty
   a_ind16: assert property (p_ind16) else $error("data pointer address wrong");

   property p_reg;
      @(posedge ref_clk) disable iff (!nrst)
      (reqValid && req.mode == COAU_REGISTER) |-> regRdAddr == {3'h0, req.bank, req.regNum};
   endproperty
   a_reg: assert property (p_reg) else $error("register select wrong");

   // register contents come back through the same-cycle read port
   property p_regval;
      @(posedge ref_clk) disable iff (!nrst)
      (reqReady && reqValid && req.mode == COAU_REGISTER) |=> opnd.value == $past(regRdData);
   endproperty
   a_regval: assert property (p_regval) else $error("register value wrong");

   property p_acc;
      @(posedge ref_clk) disable iff (!nrst)
      (reqReady && reqValid && req.mode == COAU_REGSPEC) |=> opnd.value == $past(accumulator);
   endproperty
   a_acc: assert property (p_acc) else $error("implicit operand wrong");

   property p_imm;
      @(posedge ref_clk) disable iff (!nrst)
      (reqReady && reqValid && req.mode == COAU_IMMEDIATE) |=>
         opnd.value == $past(req.field) && opnd.space == COAU_SP_VALUE;
   endproperty
   a_imm: assert property (p_imm) else $error("immediate value wrong");

   property p_idx;
      @(posedge ref_clk) disable iff (!nrst)
      (reqReady && reqValid && req.mode == COAU_INDEXED) |=>
         opnd.space == COAU_SP_CODE && opnd.addr == 16'($past(data_pointer) + $past(accumulator));
   endproperty
   a_idx: assert property (p_idx) else $error("indexed address wrong");

   property p_bit;
      @(posedge ref_clk) disable iff (!nrst)
      (reqReady && reqValid && req.mode == COAU_BIT && req.field < 8'h80) |=>
         opnd.isBit && opnd.addr == 16'h0020 + $past(req.field[6:3]) && opnd.bitPos == $past(req.field[2:0]);
   endproperty
   a_bit: assert property (p_bit) else $error("bit ram mapping wrong");

   // only a legal class can start the stall, every mode is decoded
   property p_two;
      @(posedge ref_clk) disable iff (!nrst)
      (reqReady && reqValid && req.twoCycle && req.iclass <= COAU_BRANCH) |=> !reqReady ##1 reqReady;
   endproperty
   a_two: assert property (p_two) else $error("two cycle stall wrong");

   // nothing is taken while the stream is stalled
   property p_stall;
      @(posedge ref_clk) disable iff (!nrst)
      !reqReady |=> !opndValid && !illegal;
   endproperty
   a_stall: assert property (p_stall) else $error("request taken in stall");

   // an unknown class is flagged and never reaches the operand side
   property p_class;
      @(posedge ref_clk) disable iff (!nrst)
      (reqReady && reqValid && req.iclass > COAU_BRANCH) |=> illegal && !opndValid;
   endproperty
   a_class: assert property (p_class) else $error("bad class accepted");
endmodule

// ==== tb/coau_reg_model.sv ====
// behavioural general-register store behind the read port
`timescale 1ns/1ps
module coau_reg_model
   import coau_pkg::*;
(
   input wire logic [7:0] regRdAddr,
   output logic [DATA_W-1:0] regRdData
);
   // inverted address as content, so every bank slot reads distinct
   assign regRdData = ~regRdAddr;
endmodule

// ==== tb/cpu_operand_addressing_unit_tb.sv ====
// self-checking bench for the operand addressing unit
`timescale 1ns/1ps
module cpu_operand_addressing_unit_tb;
   import coau_pkg::*;
   logic ref_clk;
   logic nrst;
   logic reqValid;
   coau_req_t req;
   logic [7:0] accumulator;
   logic [15:0] data_pointer;
   logic [7:0] regRdData;
   logic [7:0] regRdAddr;
   logic reqReady;
   logic opndValid;
   coau_opnd_t opnd;
   logic illegal;
   int n_mismatch;
   int total_checks;
   coau_operand_unit uut (.ref_clk(ref_clk), .nrst(nrst), .reqValid(reqValid), .req(req),
      .accumulator(accumulator), .data_pointer(data_pointer), .regRdData(regRdData),
      .regRdAddr(regRdAddr), .reqReady(reqReady), .opndValid(opndValid), .opnd(opnd), .illegal(illegal));
   coau_reg_model regs (.regRdAddr(regRdAddr), .regRdData(regRdData));
   // free-running core clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic bad(input string msg);
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // request held until an edge that finds reqReady high; valid stays up for the next call
   task automatic go(input coau_mode_t m, input coau_class_t c, input logic [7:0] f,
      input logic [2:0] rn, input logic p, input logic [1:0] b, input logic two, input logic [7:0] ra);
      req = '{mode: m, iclass: c, regNum: rn, ptrSel: p, field: f, bank: b, twoCycle: two};
      reqValid = 1'b1;
      #20 total_checks++;
      if (regRdAddr !== ra) bad("read port address");
      while (reqReady !== 1'b1) begin
         @(posedge ref_clk);
         #20;
      end
      @(posedge ref_clk);
      #1;
   endtask
   task automatic got(input coau_space_t s, input logic [15:0] a);
      total_checks += 2;
      if (opndValid !== 1'b1 || opnd.space !== s) bad("valid or space");
      if (opnd.addr !== a) bad("operand address");
   endtask
   task automatic val(input logic [7:0] v);
      total_checks++;
      if (opndValid !== 1'b1 || opnd.value !== v) bad("operand value");
   endtask
   task automatic t_addr;
      go(COAU_DIRECT, COAU_ARITH, 8'h45, 3'h0, 1'b0, 2'h0, 1'b0, 8'h00);
      got(COAU_SP_IRAM, 16'h0045);
      go(COAU_DIRECT, COAU_ARITH, 8'hA0, 3'h0, 1'b0, 2'h0, 1'b0, 8'h00);
      got(COAU_SP_SFR, 16'h00A0);
      go(COAU_INDIRECT8, COAU_XFER, 8'h00, 3'h0, 1'b1, 2'h2, 1'b0, 8'h11);
      got(COAU_SP_IRAM, 16'h00EE);
      go(COAU_INDIRECT16, COAU_XFER, 8'h00, 3'h0, 1'b0, 2'h0, 1'b0, 8'h00);
      got(COAU_SP_XDATA, 16'h12F0);
      go(COAU_REGISTER, COAU_ARITH, 8'h00, 3'h7, 1'b0, 2'h3, 1'b0, 8'h1F);
      val(8'hE0);
      got(COAU_SP_IRAM, 16'h001F);
      go(COAU_IMMEDIATE, COAU_LOGIC, 8'h5C, 3'h0, 1'b0, 2'h0, 1'b0, 8'h00);
      val(8'h5C);
      go(COAU_INDEXED, COAU_XFER, 8'h00, 3'h0, 1'b0, 2'h0, 1'b0, 8'h00);
      got(COAU_SP_CODE, 16'h1310);
   endtask
   // bits 0x00..0x7F land in RAM from 0x20, the rest in special registers
   task automatic t_bit;
      go(COAU_BIT, COAU_BOOL, 8'h0B, 3'h0, 1'b0, 2'h0, 1'b0, 8'h00);
      got(COAU_SP_IRAM, 16'h0021);
      go(COAU_BIT, COAU_BOOL, 8'h93, 3'h0, 1'b0, 2'h0, 1'b0, 8'h00);
      got(COAU_SP_SFR, 16'h0090);
      total_checks++;
      if (opnd.isBit !== 1'b1 || opnd.bitPos !== 3'h3) bad("bit select");
   endtask
   task automatic t_class;
      for (int c = 0; c < 6; c++) begin
         go(COAU_REGSPEC, coau_class_t'(c), 8'h00, 3'h0, 1'b0, 2'h0, 1'b0, 8'h00);
         total_checks++;
         if (c < 5 && (opndValid !== 1'b1 || opnd.iclass !== coau_class_t'(c))) bad("class");
         if (c == 5 && (opndValid !== 1'b0 || illegal !== 1'b1)) bad("bad class taken");
         total_checks++;
         if (c < 5 && (opnd.value !== 8'h20 || opnd.space !== COAU_SP_VALUE)) bad("implicit operand");
      end
   endtask
   // a request offered in the stall cycle is held off one edge, then taken
   task automatic t_two;
      go(COAU_IMMEDIATE, COAU_BRANCH, 8'h33, 3'h0, 1'b0, 2'h0, 1'b1, 8'h00);
      total_checks++;
      if (reqReady !== 1'b0 || opndValid !== 1'b1 || opnd.value !== 8'h33) bad("stall missing");
      req.field = 8'h77;
      req.twoCycle = 1'b0;
      @(posedge ref_clk);
      #1 total_checks++;
      if (reqReady !== 1'b1 || opndValid !== 1'b0 || opnd.value !== 8'h33) bad("stall");
      @(posedge ref_clk);
      #1 total_checks++;
      if (opndValid !== 1'b1 || opnd.value !== 8'h77) bad("held request not taken");
   endtask
   initial begin
      nrst = 1'b0;
      reqValid = 1'b0;
      req = '0;
      accumulator = 8'h20;
      data_pointer = 16'h12F0;
      n_mismatch = 0;
      total_checks = 0;
      repeat (12) @(posedge ref_clk);
      #1 nrst = 1'b1;
      t_addr();
      t_bit();
      t_class();
      t_two();
      reqValid = 1'b0;
      close_out();
   end
   // hang guard, far beyond the few dozen cycles needed
   initial begin
      #200000;
      bad("timeout");
      close_out();
   end
endmodule
